// *** core/msad_pkg.sv ***
// msad_pkg: shared types and address map of the memory space decoder
package msad_pkg;

   localparam int ADDR_W = 16;
   localparam int PDATA_W = 24;
   localparam int XDATA_W = 16;

   // program space map
   localparam logic [15:0] P_RAM_LO = 16'h0000;
   localparam logic [15:0] P_RAM_HI = 16'h01FF;
   localparam logic [15:0] P_ROM_LO = 16'h1000;
   localparam logic [15:0] P_ROM_HI = 16'h97FF;
   localparam logic [15:0] P_EXT_LO = 16'h9800;
   localparam logic [15:0] P_EXT_HI = 16'hFFFF;
   // x data space map
   localparam logic [15:0] X_RAM_LO = 16'h0000;
   localparam logic [15:0] X_RAM_HI = 16'h10FF;
   localparam logic [15:0] X_ROM_LO = 16'h1800;
   localparam logic [15:0] X_ROM_HI = 16'h2FFF;
   localparam logic [15:0] X_IO_LO  = 16'hFF80;
   localparam logic [15:0] X_IO_HI  = 16'hFFFF;
   // y data space map
   localparam logic [15:0] Y_RAM_LO = 16'h0000;
   localparam logic [15:0] Y_RAM_HI = 16'h10FF;
   localparam logic [15:0] Y_ROM_LO = 16'h1800;
   localparam logic [15:0] Y_ROM_HI = 16'h37FF;

   // bank geometry: 256 words per bank
   localparam int BANK_SHIFT = 8;
   localparam logic [7:0] P_RAM_BANKS = 8'h02;
   localparam logic [7:0] P_ROM_BANKS = 8'h88;
   localparam logic [7:0] X_RAM_BANKS = 8'h11;
   localparam logic [7:0] X_ROM_BANKS = 8'h18;
   localparam logic [7:0] Y_RAM_BANKS = 8'h11;
   localparam logic [7:0] Y_ROM_BANKS = 8'h20;

   // value returned for a read of a reserved hole
   localparam logic [23:0] RSV_FILL = 24'h000000;

   typedef enum logic [1:0] {
      MSAD_SP_P = 2'b00,
      MSAD_SP_X = 2'b01,
      MSAD_SP_Y = 2'b10
   } msad_space_e;

   typedef enum logic [2:0] {
      MSAD_OP_MOVE                        = 3'b000,
      MSAD_OP_PERIPHERAL_MOVE_INSTRUCTION = 3'b001,
      MSAD_OP_BIT_TEST_INSTRUCTION        = 3'b010,
      MSAD_OP_BIT_SET                     = 3'b011,
      MSAD_OP_BIT_CLEAR                   = 3'b100,
      MSAD_OP_BIT_CHANGE_INSTRUCTION      = 3'b101
   } msad_op_e;

   typedef struct packed {
      logic        valid;
      msad_space_e space;
      logic [15:0] addr;
      logic        rd;
      logic        wr;
      msad_op_e    op;
      logic [23:0] wdata;
   } msad_req_s;

   typedef struct packed {
      logic p_ram;
      logic p_rom;
      logic p_ext;
      logic x_ram;
      logic x_rom;
      logic x_io;
      logic y_ram;
      logic y_rom;
   } msad_sel_s;

   typedef struct packed {
      msad_sel_s   sel;
      logic [7:0]  bank;
      logic [7:0]  offset;
      logic [15:0] addr;
      logic        rd;
      logic        wr;
      logic        rmw;
      logic [23:0] wdata;
   } msad_tgt_s;

endpackage : msad_pkg

// *** core/msad_range.sv ***
// msad_range: inclusive address window match with bank index
`timescale 1ns/100ps
module msad_range #(
   parameter logic [15:0] LO = 16'h0000,
   parameter logic [15:0] HI = 16'hFFFF
) (
   // address in
   input  wire logic [15:0] addr,
   // match out
   output logic             hit,
   output logic [7:0]       bank
);
   logic [15:0] rel;

   assign rel  = addr - LO;
   assign hit  = (addr >= LO) && (addr <= HI);
   assign bank = rel[15:8];

endmodule : msad_range

// *** core/msad_decoder.sv ***
// msad_decoder: program, x and y space decode to on-chip targets
//
// Overview of operation
// - three spaces decode independently of each other
// - program 0000-01FF selects 24-bit program RAM
// - program RAM: two 256-word banks
// - program 1000-97FF selects ROM, 136 banks
// - program 9800-FFFF goes to external port
// - x 0000-10FF selects x RAM, 17 banks
// - x 1800-2FFF selects x ROM, 24 banks
// - x FF80 upward is peripheral register window
// - window takes moves and bit operations
// - y 0000-10FF selects y RAM, 17 banks
// - y 1800-37FF selects y ROM, 32 banks
`timescale 1ns/100ps
module msad_decoder (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // request from core
   input  wire msad_pkg::msad_req_s req,
   // decoded access toward targets
   output msad_pkg::msad_tgt_s    tgt,
   output logic                   tgt_valid,
   // reserved hole answer and dropped ROM write flag
   output logic                   rsv_hit,
   output logic                   rsv_rvalid,
   output logic [23:0]            rsv_rdata,
   output logic                   rom_wr_drop
);
   import msad_pkg::*;

   logic       h_pram, h_prom, h_pext, h_xram, h_xrom, h_xio, h_yram, h_yrom;
   logic [7:0] b_pram, b_prom, b_pext, b_xram, b_xrom, b_xio, b_yram, b_yrom;
   msad_sel_s  sel_next;
   logic [7:0] bank_next;
   logic       is_rom;
   logic       is_bitop;
   logic       any_sel;

   // window matchers, one per target
   msad_range #(.LO(P_RAM_LO), .HI(P_RAM_HI)) u_pram (
      .addr (req.addr),
      .hit  (h_pram),
      .bank (b_pram)
   );
   msad_range #(.LO(P_ROM_LO), .HI(P_ROM_HI)) u_prom (
      .addr (req.addr),
      .hit  (h_prom),
      .bank (b_prom)
   );
   msad_range #(.LO(P_EXT_LO), .HI(P_EXT_HI)) u_pext (
      .addr (req.addr),
      .hit  (h_pext),
      .bank (b_pext)
   );
   msad_range #(.LO(X_RAM_LO), .HI(X_RAM_HI)) u_xram (
      .addr (req.addr),
      .hit  (h_xram),
      .bank (b_xram)
   );
   msad_range #(.LO(X_ROM_LO), .HI(X_ROM_HI)) u_xrom (
      .addr (req.addr),
      .hit  (h_xrom),
      .bank (b_xrom)
   );
   msad_range #(.LO(X_IO_LO), .HI(X_IO_HI)) u_xio (
      .addr (req.addr),
      .hit  (h_xio),
      .bank (b_xio)
   );
   msad_range #(.LO(Y_RAM_LO), .HI(Y_RAM_HI)) u_yram (
      .addr (req.addr),
      .hit  (h_yram),
      .bank (b_yram)
   );
   msad_range #(.LO(Y_ROM_LO), .HI(Y_ROM_HI)) u_yrom (
      .addr (req.addr),
      .hit  (h_yrom),
      .bank (b_yrom)
   );

   // the space tag qualifies every window
   always_comb begin
      sel_next       = '0;
      bank_next      = 8'h00;
      if (req.valid) begin
         case (req.space)
            MSAD_SP_P: begin
               sel_next.p_ram = h_pram;
               sel_next.p_rom = h_prom;
               sel_next.p_ext = h_pext;
            end
            MSAD_SP_X: begin
               sel_next.x_ram = h_xram;
               sel_next.x_rom = h_xrom;
               sel_next.x_io  = h_xio;
            end
            MSAD_SP_Y: begin
               sel_next.y_ram = h_yram;
               sel_next.y_rom = h_yrom;
            end
            default: begin
               sel_next = '0;
            end
         endcase
      end
      // bank is the address above the low eight, relative to the base
      if (sel_next.p_ram) begin
         bank_next = b_pram;
      end else if (sel_next.p_rom) begin
         bank_next = b_prom;
      end else if (sel_next.p_ext) begin
         bank_next = b_pext;
      end else if (sel_next.x_ram) begin
         bank_next = b_xram;
      end else if (sel_next.x_rom) begin
         bank_next = b_xrom;
      end else if (sel_next.x_io) begin
         bank_next = b_xio;
      end else if (sel_next.y_ram) begin
         bank_next = b_yram;
      end else if (sel_next.y_rom) begin
         bank_next = b_yrom;
      end
   end

   assign is_rom  = sel_next.p_rom | sel_next.x_rom | sel_next.y_rom;
   assign any_sel = |sel_next;
   assign is_bitop = (req.op == MSAD_OP_BIT_SET)
                  || (req.op == MSAD_OP_BIT_CLEAR)
                  || (req.op == MSAD_OP_BIT_CHANGE_INSTRUCTION);

   // decoded access, registered one cycle after the request
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tgt       <= '0;
         tgt_valid <= 1'b0;
      end else begin
         tgt_valid  <= any_sel;
         tgt.sel    <= sel_next;
         tgt.bank   <= bank_next;
         tgt.offset <= req.addr[7:0];
         tgt.addr   <= req.addr;
         tgt.rd     <= any_sel & req.rd;
         // rom contents never see a write strobe
         tgt.wr     <= any_sel & req.wr & ~is_rom;
         // window accepts any op; bit set, clear and change read then write back
         tgt.rmw    <= sel_next.x_io & is_bitop;
         tgt.wdata  <= req.wdata;
      end
   end

   // reserved holes: no select, reads answered with a fixed word
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rsv_hit     <= 1'b0;
         rsv_rvalid  <= 1'b0;
         rsv_rdata   <= 24'h000000;
         rom_wr_drop <= 1'b0;
      end else begin
         rsv_hit     <= req.valid & ~any_sel;
         rsv_rvalid  <= req.valid & ~any_sel & req.rd;
         rsv_rdata   <= RSV_FILL;
         rom_wr_drop <= req.valid & is_rom & req.wr;
      end
   end

   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   function automatic logic rsv_data_ok(input logic [23:0] d);
      rsv_data_ok = (d == RSV_FILL);
   endfunction : rsv_data_ok

   chk_one_select: assert property ($onehot0(tgt.sel))
      else $error("more than one target selected");

   chk_sel_vs_valid: assert property (tgt_valid == (|tgt.sel))
      else $error("valid disagrees with selects");

   chk_pram_range: assert property (
      req.valid && req.space == MSAD_SP_P && req.addr <= P_RAM_HI
      |=> tgt.sel.p_ram && tgt.bank == {7'h00, tgt.addr[8]})
      else $error("program RAM not selected");

   chk_pram_bank: assert property (
      tgt.sel.p_ram |-> tgt.bank < P_RAM_BANKS)
      else $error("program RAM bank out of range");

   chk_prom_range: assert property (
      req.valid && req.space == MSAD_SP_P
      && req.addr >= P_ROM_LO && req.addr <= P_ROM_HI
      |=> tgt.sel.p_rom && tgt.bank < P_ROM_BANKS)
      else $error("program ROM not selected");

   chk_p_hole: assert property (
      req.valid && req.space == MSAD_SP_P
      && req.addr > P_RAM_HI && req.addr < P_ROM_LO
      |=> rsv_hit && !tgt_valid)
      else $error("program hole not flagged");

   chk_pext_range: assert property (
      req.valid && req.space == MSAD_SP_P && req.addr >= P_EXT_LO
      |=> tgt.sel.p_ext)
      else $error("external port not selected");

   chk_xram_range: assert property (
      req.valid && req.space == MSAD_SP_X && req.addr <= X_RAM_HI
      |=> tgt.sel.x_ram && tgt.bank < X_RAM_BANKS)
      else $error("x RAM not selected");

   chk_xrom_range: assert property (
      req.valid && req.space == MSAD_SP_X
      && req.addr >= X_ROM_LO && req.addr <= X_ROM_HI
      |=> tgt.sel.x_rom && tgt.bank < X_ROM_BANKS)
      else $error("x ROM not selected");

   chk_xio_window: assert property (
      req.valid && req.space == MSAD_SP_X && req.addr >= X_IO_LO
      |=> tgt.sel.x_io && tgt.addr[15:7] == 9'h1FF)
      else $error("x window not selected");

   chk_xio_bitop: assert property (
      req.valid && req.space == MSAD_SP_X && req.addr >= X_IO_LO
      && req.op == MSAD_OP_BIT_CHANGE_INSTRUCTION
      |=> tgt.rmw && tgt_valid)
      else $error("bit change not taken in window");

   chk_xio_plain: assert property (
      req.valid && req.space == MSAD_SP_X && req.addr >= X_IO_LO
      && (req.op == MSAD_OP_MOVE
      || req.op == MSAD_OP_PERIPHERAL_MOVE_INSTRUCTION
      || req.op == MSAD_OP_BIT_TEST_INSTRUCTION)
      |=> tgt.sel.x_io && tgt_valid && !tgt.rmw)
      else $error("plain op not taken in window");

   chk_x_hole: assert property (
      req.valid && req.space == MSAD_SP_X
      && ((req.addr > X_RAM_HI && req.addr < X_ROM_LO)
      || (req.addr > X_ROM_HI && req.addr < X_IO_LO))
      |=> rsv_hit && !tgt_valid)
      else $error("x hole not flagged");

   chk_yram_range: assert property (
      req.valid && req.space == MSAD_SP_Y && req.addr <= Y_RAM_HI
      |=> tgt.sel.y_ram && tgt.bank < Y_RAM_BANKS)
      else $error("y RAM not selected");

   chk_yrom_range: assert property (
      req.valid && req.space == MSAD_SP_Y
      && req.addr >= Y_ROM_LO && req.addr <= Y_ROM_HI
      |=> tgt.sel.y_rom && tgt.bank < Y_ROM_BANKS)
      else $error("y ROM not selected");

   chk_y_hole: assert property (
      req.valid && req.space == MSAD_SP_Y && req.addr > Y_ROM_HI
      |=> rsv_hit ##0 !tgt_valid)
      else $error("y hole not flagged");

   chk_space_none: assert property (
      req.valid && req.space == 2'b11 |=> rsv_hit && !tgt_valid)
      else $error("unused space code not refused");

   chk_rsv_read: assert property (
      rsv_rvalid |-> rsv_data_ok(rsv_rdata) && rsv_hit)
      else $error("reserved read value wrong");

   chk_rom_nowrite: assert property (
      req.valid && req.wr
      && ((req.space == MSAD_SP_P && req.addr >= P_ROM_LO
      && req.addr <= P_ROM_HI)
      || (req.space == MSAD_SP_X && req.addr >= X_ROM_LO
      && req.addr <= X_ROM_HI)
      || (req.space == MSAD_SP_Y && req.addr >= Y_ROM_LO
      && req.addr <= Y_ROM_HI))
      |=> !tgt.wr && rom_wr_drop && tgt_valid)
      else $error("write reached ROM");

   chk_strobe_valid: assert property (
      (tgt.rd || tgt.wr || tgt.rmw) |-> tgt_valid)
      else $error("strobe without a selected target");

   chk_idle_quiet: assert property (
      !req.valid |=> !tgt_valid && !rsv_hit && !rom_wr_drop)
      else $error("output without a request");

   chk_addr_copy: assert property (
      req.valid |=> tgt.addr == $past(req.addr))
      else $error("target address not the request address");

   cov_pram_write: cover property (tgt_valid && tgt.sel.p_ram && tgt.wr);
   cov_xio_rmw: cover property (tgt.sel.x_io && tgt.rmw);
   cov_hole_read: cover property (rsv_rvalid);
   cov_rom_drop: cover property (rom_wr_drop ##1 tgt.sel.p_ext);

endmodule : msad_decoder

// *** verification/msad_core_model.sv ***
// msad_core_model: request side model of the processor core
`timescale 1ns/100ps
module msad_core_model (
   // clock
   input  wire logic           clk,
   // request toward the decoder
   output msad_pkg::msad_req_s req
);
   import msad_pkg::*;

   initial req = '0;

   // called at a falling edge; request stands until the next call
   // reserved holes are entered only when a scenario asks for one
   task automatic put(input logic v, input logic [1:0] sp,
                      input logic [15:0] a, input logic r,
                      input logic w, input logic [2:0] op,
                      input logic [23:0] d);
      req.valid <= v;
      req.space <= msad_space_e'(sp);
      req.addr  <= a;
      req.rd    <= r;
      req.wr    <= w;
      req.op    <= msad_op_e'(op);
      // write data is not held when no write is made
      req.wdata <= w ? d : ~req.wdata;
   endtask : put
endmodule : msad_core_model

// *** verification/tb.sv ***
// tb: self-checking bench of the memory space decoder
`timescale 1ns/100ps
module tb;
   import msad_pkg::*;

   logic        clk;
   logic        sys_rst;
   msad_req_s   req;
   msad_tgt_s   tgt;
   logic        tgt_valid;
   logic        rsv_hit;
   logic        rsv_rvalid;
   logic [23:0] rsv_rdata;
   logic        rom_wr_drop;
   int          mismatches;
   int          n_compared;
   int          cycles;

   msad_core_model u_core (.clk(clk), .req(req));

   msad_decoder u_dut (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .req        (req),
      .tgt        (tgt),
      .tgt_valid  (tgt_valid),
      .rsv_hit    (rsv_hit),
      .rsv_rvalid (rsv_rvalid),
      .rsv_rdata  (rsv_rdata),
      .rom_wr_drop(rom_wr_drop)
   );

   always #10 clk = ~clk;

   task automatic check(input string what, input logic [23:0] seen,
                        input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic complete_run;
      $display("compared %0d mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         mismatches++;
         complete_run();
      end
   end

   function automatic logic [15:0] hit(logic [7:0] s, logic [15:0] a,
                                       logic [15:0] lo);
      logic [15:0] d;
      d = a - lo;
      return {s, d[15:8]};
   endfunction : hit

   // expected select and bank of one access, zero for a hole
   function automatic logic [15:0] expect_map(int sp, logic [15:0] a);
      if (sp == 0 && a <= P_RAM_HI) return hit(8'h80, a, P_RAM_LO);
      if (sp == 0 && a >= P_ROM_LO && a <= P_ROM_HI)
         return hit(8'h40, a, P_ROM_LO);
      if (sp == 0 && a >= P_EXT_LO) return hit(8'h20, a, P_EXT_LO);
      if (sp == 1 && a <= X_RAM_HI) return hit(8'h10, a, X_RAM_LO);
      if (sp == 1 && a >= X_ROM_LO && a <= X_ROM_HI)
         return hit(8'h08, a, X_ROM_LO);
      if (sp == 1 && a >= X_IO_LO) return hit(8'h04, a, X_IO_LO);
      if (sp == 2 && a <= Y_RAM_HI) return hit(8'h02, a, Y_RAM_LO);
      if (sp == 2 && a >= Y_ROM_LO && a <= Y_ROM_HI)
         return hit(8'h01, a, Y_ROM_LO);
      return 16'h0000;
   endfunction : expect_map

   // every space against each region edge except the top end FFFF, back to back
   task automatic sweep(input logic w);
      logic [15:0] addrs [18] = '{16'h0000, 16'h01FF, 16'h0200, 16'h0FFF,
         16'h1000, 16'h10FF, 16'h1100, 16'h17FF, 16'h1800, 16'h2FFF,
         16'h3000, 16'h37FF, 16'h3800, 16'h97FF, 16'h9800, 16'h9FFF,
         16'hFF7F, 16'hFF80};
      logic [15:0] e;
      logic [7:0]  s;
      logic        rom;
      for (int sp = 0; sp < 4; sp++) begin
         for (int i = 0; i < 18; i++) begin
            u_core.put(1'b1, 2'(sp), addrs[i], !w, w, 3'h0, 24'hA5C300);
            @(negedge clk);
            e = expect_map(sp, addrs[i]);
            s = e[15:8];
            rom = |(s & 8'h49);
            check("sel", tgt.sel, s);
            check("addr", tgt.addr, addrs[i]);
            check("bank", tgt.bank, e[7:0]);
            check("offset", tgt.offset, addrs[i][7:0]);
            check("tgt_valid", tgt_valid, s != 0);
            check("rsv_hit", rsv_hit, s == 0);
            check("rsv_rvalid", rsv_rvalid, s == 0 && !w);
            check("rsv_rdata", rsv_rdata, 24'h000000);
            check("rd", tgt.rd, !w && s != 0);
            check("wr", tgt.wr, w && s != 0 && !rom);
            check("rom_wr_drop", rom_wr_drop, w && rom);
         end
      end
   endtask : sweep

   task automatic test_reads;
      sweep(1'b0);
      $display("test reads done");
   endtask : test_reads

   task automatic test_writes;
      sweep(1'b1);
      $display("test writes done");
   endtask : test_writes

   // every operation kind into the peripheral window
   task automatic test_io_ops;
      for (int op = 0; op < 6; op++) begin
         u_core.put(1'b1, 2'h1, 16'hFFC5, 1'b0, 1'b1, 3'(op), 24'h00BEEF);
         @(negedge clk);
         check("io sel", tgt.sel, 8'h04);
         check("io wr", tgt.wr, 1'b1);
         check("io wdata", tgt.wdata, 24'h00BEEF);
         check("io rmw", tgt.rmw, op >= 3);
      end
      u_core.put(1'b0, 2'h1, 16'hFFC5, 1'b0, 1'b0, 3'h0, 24'h000000);
      @(negedge clk);
      check("idle valid", tgt_valid, 1'b0);
      $display("test io ops done");
   endtask : test_io_ops

   // reset in mid-run clears the answer to a standing request
   task automatic test_reset;
      u_core.put(1'b1, 2'h2, 16'h4000, 1'b1, 1'b0, 3'h0, 24'h000000);
      sys_rst = 1'b1;
      @(negedge clk);
      check("rst rsv_hit", rsv_hit, 1'b0);
      check("rst rvalid", rsv_rvalid, 1'b0);
      check("rst valid", tgt_valid, 1'b0);
      sys_rst = 1'b0;
      @(negedge clk);
      check("after rsv_hit", rsv_hit, 1'b1);
      $display("test reset done");
   endtask : test_reset

   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      mismatches = 0;
      n_compared = 0;
      cycles = 0;
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      test_reads();
      test_writes();
      test_io_ops();
      test_reset();
      complete_run();
   end
endmodule : tb
